// ===== logic/txwb_core.sv
`timescale 1ns/1ps
module txwb_core
(
    input wire logic ref_clk_i,
    input wire logic reset_n_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [15:0] reg_wdata_i,
    input wire logic reg_we_i,
    input wire logic reg_re_i,
    output logic [15:0] reg_rdata_o,
    input wire logic desc_load_i,
    input wire logic [15:0] desc_flags_i,
    input wire logic [15:0] desc_count_i,
    output logic desc_ready_o,
    input wire logic byte_take_i,
    output logic [11:0] bytes_left_o,
    output logic crc_enable_o,
    output logic sending_o,
    input wire logic attempt_fail_i,
    input wire logic late_coll_i,
    input wire logic carrier_lost_i,
    input wire logic underflow_i,
    input wire logic next_status_i,
    input wire logic next_own_i,
    output logic retry_req_o,
    output logic wb_valid_o,
    output logic [15:0] wb_flags_o,
    output logic [15:0] wb_status_o,
    output logic [15:0] wb_count_o,
    output logic transmitter_on_o,
    output logic irq_o
);
    txwb_pkg::txwb_state_e state_q;
    logic [15:0] flags_q;
    logic [15:0] count_q;
    logic [11:0] left_q;
    logic [11:0] desc_len;
    logic [4:0] fails_q;
    logic in_frame_q;
    logic crc_en_q;
    logic buffer_error_flag_q, underflow_flag_q, late_collision_flag_q, carrier_loss_flag_q, retry_error_flag_q;
    logic final_q;
    logic transmitter_on_q;
    logic disable_retry_q;
    logic disable_tx_crc_q;
    logic [2:0] int_stat_q;
    logic [2:0] int_mask_q;
    logic [2:0] int_ev;
    logic [15:0] reg_rd_q;
    logic log_sel_q;
    logic [15:0] log_rdata;
    logic [2:0] log_ptr_q;
    logic log_hit;
    logic desc_take;
    logic in_send, in_wait;
    logic ev_late_collision_flag, ev_underflow_flag, ev_fail, ev_last_fail, ev_retry, ev_buf_end;
    logic wait_bad, wait_good;
    logic transmitter_on_kill;
    logic err_sum;

    assign in_send = (state_q == txwb_pkg::ST_SEND);
    assign in_wait = (state_q == txwb_pkg::ST_WAIT_NEXT);
    assign desc_ready_o = (state_q == txwb_pkg::ST_IDLE) && transmitter_on_q;
    // skip descriptors not owned, or not a frame start outside a chain
    assign desc_take = desc_load_i && desc_ready_o && desc_flags_i[txwb_pkg::OWN_BIT]
        && (in_frame_q || desc_flags_i[txwb_pkg::STP_BIT]);
    // zero field gives zero bytes, so empty buffers pass straight through
    assign desc_len = 12'(~desc_count_i[txwb_pkg::LEN_MSB:0] + 12'h001);

    // send-state events, in priority order
    assign ev_late_collision_flag = in_send && late_coll_i;
    assign ev_underflow_flag = in_send && !ev_late_collision_flag && underflow_i;
    assign ev_fail = in_send && !ev_late_collision_flag && !ev_underflow_flag && attempt_fail_i;
    assign ev_last_fail = ev_fail && (disable_retry_q || fails_q == txwb_pkg::LAST_FAIL);
    assign ev_retry = ev_fail && !ev_last_fail;
    assign ev_buf_end = in_send && !ev_late_collision_flag && !ev_underflow_flag && !ev_fail && left_q == txwb_pkg::LEN_RST;
    assign wait_bad = in_wait && (underflow_i || (next_status_i && !next_own_i));
    assign wait_good = in_wait && !underflow_i && next_status_i && next_own_i;
    assign transmitter_on_kill = ev_underflow_flag || wait_bad;
    assign err_sum = underflow_flag_q || late_collision_flag_q || carrier_loss_flag_q || retry_error_flag_q;

    always_ff @(posedge ref_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            state_q <= txwb_pkg::ST_IDLE;
        end
        else
        begin
            case (state_q)
                txwb_pkg::ST_IDLE:
                begin
                    if (desc_take)
                    begin
                        state_q <= txwb_pkg::ST_SEND;
                    end
                end
                txwb_pkg::ST_SEND:
                begin
                    if (ev_late_collision_flag || ev_underflow_flag || ev_last_fail)
                    begin
                        state_q <= txwb_pkg::ST_WB;
                    end
                    else if (ev_buf_end)
                    begin
                        // a buffer with both frame marks never chains
                        state_q <= flags_q[txwb_pkg::ENP_BIT] ? txwb_pkg::ST_WB
                                                             : txwb_pkg::ST_WAIT_NEXT;
                    end
                end
                txwb_pkg::ST_WAIT_NEXT:
                begin
                    if (wait_bad || wait_good)
                    begin
                        state_q <= txwb_pkg::ST_WB;
                    end
                end
                txwb_pkg::ST_WB:
                begin
                    state_q <= txwb_pkg::ST_IDLE;
                end
                default:
                begin
                    state_q <= txwb_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // descriptor words are held verbatim and only the status bits change
    always_ff @(posedge ref_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            flags_q <= txwb_pkg::WORD_RST;
            count_q <= txwb_pkg::WORD_RST;
        end
        else if (desc_take)
        begin
            flags_q <= desc_flags_i;
            count_q <= desc_count_i;
        end
    end

    always_ff @(posedge ref_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            left_q <= txwb_pkg::LEN_RST;
        end
        else if (desc_take)
        begin
            left_q <= desc_len;
        end
        else if (ev_retry)
        begin
            // retry restarts the current buffer only
            left_q <= 12'(~count_q[txwb_pkg::LEN_MSB:0] + 12'h001);
        end
        else if (in_send && byte_take_i && left_q != txwb_pkg::LEN_RST)
        begin
            left_q <= left_q - 12'h001;
        end
    end

    always_ff @(posedge ref_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            fails_q <= txwb_pkg::FAILS_RST;
            in_frame_q <= 1'b0;
            crc_en_q <= 1'b0;
        end
        else
        begin
            if (desc_take && !in_frame_q)
            begin
                fails_q <= txwb_pkg::FAILS_RST;
                crc_en_q <= desc_flags_i[txwb_pkg::CRC_BIT] || !disable_tx_crc_q;
            end
            else if (ev_retry)
            begin
                // counts retries: the attempt that ends in retry error is not one
                fails_q <= fails_q + 5'h01;
            end
            if (desc_take)
            begin
                in_frame_q <= 1'b1;
            end
            else if (state_q == txwb_pkg::ST_WB)
            begin
                in_frame_q <= !final_q;
            end
        end
    end

    // per-descriptor error flags
    always_ff @(posedge ref_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            buffer_error_flag_q <= 1'b0;
            underflow_flag_q <= 1'b0;
            late_collision_flag_q <= 1'b0;
            carrier_loss_flag_q <= 1'b0;
            retry_error_flag_q <= 1'b0;
            final_q <= 1'b0;
        end
        else if (desc_take)
        begin
            buffer_error_flag_q <= 1'b0;
            underflow_flag_q <= 1'b0;
            late_collision_flag_q <= 1'b0;
            carrier_loss_flag_q <= 1'b0;
            retry_error_flag_q <= 1'b0;
            final_q <= 1'b0;
        end
        else
        begin
            if (ev_late_collision_flag)
            begin
                late_collision_flag_q <= 1'b1;
            end
            if (ev_underflow_flag || wait_bad)
            begin
                underflow_flag_q <= 1'b1;
            end
            if (wait_bad)
            begin
                buffer_error_flag_q <= 1'b1;
            end
            if (ev_last_fail)
            begin
                retry_error_flag_q <= 1'b1;
            end
            // flag only; the frame carries on to its end
            if ((in_send || in_wait) && carrier_lost_i)
            begin
                carrier_loss_flag_q <= 1'b1;
            end
            if (ev_late_collision_flag || ev_underflow_flag || ev_last_fail || wait_bad
                || (ev_buf_end && flags_q[txwb_pkg::ENP_BIT]))
            begin
                final_q <= 1'b1;
            end
        end
    end

    // writeback words and the retry strobe
    always_ff @(posedge ref_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            wb_valid_o <= 1'b0;
            wb_flags_o <= txwb_pkg::WORD_RST;
            wb_status_o <= txwb_pkg::WORD_RST;
            wb_count_o <= txwb_pkg::WORD_RST;
            retry_req_o <= 1'b0;
        end
        else
        begin
            retry_req_o <= ev_retry;
            wb_valid_o <= (state_q == txwb_pkg::ST_WB);
            if (state_q == txwb_pkg::ST_WB)
            begin
                wb_flags_o <= flags_q;
                wb_flags_o[txwb_pkg::OWN_BIT] <= 1'b0;
                wb_flags_o[txwb_pkg::ERR_BIT] <= err_sum;
                wb_flags_o[txwb_pkg::MORE_BIT] <= (final_q || err_sum) && fails_q > 5'h01;
                wb_flags_o[txwb_pkg::ONE_BIT] <= (final_q || err_sum) && fails_q == 5'h01;
                wb_count_o <= count_q;
                wb_status_o <= txwb_pkg::WORD_RST;
                wb_status_o[txwb_pkg::BUFFER_ERROR_FLAG_BIT] <= buffer_error_flag_q;
                wb_status_o[txwb_pkg::UNDERFLOW_FLAG_BIT] <= underflow_flag_q;
                wb_status_o[txwb_pkg::LATE_COLLISION_FLAG_BIT] <= late_collision_flag_q;
                wb_status_o[txwb_pkg::CARRIER_LOSS_FLAG_BIT] <= carrier_loss_flag_q;
                wb_status_o[txwb_pkg::RETRY_ERROR_FLAG_BIT] <= retry_error_flag_q;
            end
        end
    end

    assign bytes_left_o = left_q;
    assign crc_enable_o = crc_en_q;
    assign sending_o = in_send;
    assign transmitter_on_o = transmitter_on_q;

    // control register; a hardware stop beats a software start in one cycle
    always_ff @(posedge ref_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            transmitter_on_q <= 1'b0;
            disable_retry_q <= 1'b0;
            disable_tx_crc_q <= 1'b0;
        end
        else
        begin
            if (transmitter_on_kill)
            begin
                transmitter_on_q <= 1'b0;
            end
            else if (reg_we_i && reg_addr_i == txwb_pkg::REG_CTRL)
            begin
                transmitter_on_q <= reg_wdata_i[txwb_pkg::CTRL_TRANSMITTER_ON_BIT];
            end
            if (reg_we_i && reg_addr_i == txwb_pkg::REG_CTRL)
            begin
                disable_retry_q <= reg_wdata_i[txwb_pkg::CTRL_DISABLE_RETRY_BIT];
                disable_tx_crc_q <= reg_wdata_i[txwb_pkg::CTRL_DISABLE_TX_CRC_BIT];
            end
        end
    end

    // interrupt status: write one to clear, a new event wins
    assign int_ev[txwb_pkg::INT_DONE_BIT] = wb_valid_o && (wb_flags_o[txwb_pkg::ENP_BIT]
        || wb_flags_o[txwb_pkg::ERR_BIT]);
    assign int_ev[txwb_pkg::INT_ERR_BIT] = wb_valid_o && wb_flags_o[txwb_pkg::ERR_BIT];
    assign int_ev[txwb_pkg::INT_BUFFER_ERROR_FLAG_BIT] = wb_valid_o && wb_status_o[txwb_pkg::BUFFER_ERROR_FLAG_BIT];

    always_ff @(posedge ref_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            int_stat_q <= txwb_pkg::INT_RST;
            int_mask_q <= txwb_pkg::INT_RST;
        end
        else
        begin
            if (reg_we_i && reg_addr_i == txwb_pkg::REG_INT_STATUS)
            begin
                int_stat_q <= (int_stat_q & ~reg_wdata_i[txwb_pkg::INT_W-1:0]) | int_ev;
            end
            else
            begin
                int_stat_q <= int_stat_q | int_ev;
            end
            if (reg_we_i && reg_addr_i == txwb_pkg::REG_INT_MASK)
            begin
                int_mask_q <= reg_wdata_i[txwb_pkg::INT_W-1:0];
            end
        end
    end

    assign irq_o = |(int_stat_q & int_mask_q);

    // status log of every writeback, readable through a window
    always_ff @(posedge ref_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            log_ptr_q <= txwb_pkg::LOG_PTR_RST;
        end
        else if (wb_valid_o)
        begin
            log_ptr_q <= log_ptr_q + 3'h1;
        end
    end

    assign log_hit = reg_addr_i[7:5] == txwb_pkg::REG_LOG_BASE[7:5] && reg_addr_i[1:0] == 2'h0;

    txwb_log_mem u_log
    (
        .ref_clk_i(ref_clk_i),
        .wr_en_i(wb_valid_o),
        .wr_addr_i(log_ptr_q),
        .wr_data_i(wb_status_o),
        .rd_en_i(reg_re_i && log_hit),
        .rd_addr_i(reg_addr_i[4:2]),
        .rd_data_o(log_rdata)
    );

    always_ff @(posedge ref_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            reg_rd_q <= txwb_pkg::WORD_RST;
            log_sel_q <= 1'b0;
        end
        else
        begin
            log_sel_q <= reg_re_i && log_hit;
            reg_rd_q <= txwb_pkg::WORD_RST;
            if (reg_re_i)
            begin
                case (reg_addr_i)
                    txwb_pkg::REG_CTRL:
                        reg_rd_q <= {13'h0000, disable_tx_crc_q, disable_retry_q, transmitter_on_q};
                    txwb_pkg::REG_STATUS:
                        reg_rd_q <= {9'h000, fails_q, in_frame_q, transmitter_on_q};
                    txwb_pkg::REG_INT_STATUS:
                        reg_rd_q <= {13'h0000, int_stat_q};
                    txwb_pkg::REG_INT_MASK:
                        reg_rd_q <= {13'h0000, int_mask_q};
                    default:
                        reg_rd_q <= txwb_pkg::WORD_RST;
                endcase
            end
        end
    end

    assign reg_rdata_o = log_sel_q ? log_rdata : reg_rd_q;

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!reset_n_i);

    wb_own_clear_a: assert property (wb_valid_o |-> !wb_flags_o[txwb_pkg::OWN_BIT])
        else $error("ownership bit not cleared on writeback");
    wb_words_kept_a: assert property (wb_valid_o |-> wb_flags_o[txwb_pkg::CRC_BIT]
        == flags_q[txwb_pkg::CRC_BIT] && wb_count_o == count_q)
        else $error("host descriptor fields altered");
    len_load_a: assert property (desc_take |=> left_q
        == 12'(~$past(desc_count_i[11:0]) + 12'h001))
        else $error("buffer length not loaded as negated count");
    late_no_retry_a: assert property (ev_late_collision_flag |=> state_q == txwb_pkg::ST_WB && late_collision_flag_q
        && !retry_req_o ##1 wb_valid_o && wb_status_o[txwb_pkg::LATE_COLLISION_FLAG_BIT])
        else $error("late collision mishandled");
    retry_limit_a: assert property (ev_fail && fails_q == txwb_pkg::LAST_FAIL |=> retry_error_flag_q
        && !retry_req_o)
        else $error("retry error missing at attempt limit");
    no_retry_mode_a: assert property (ev_fail && disable_retry_q |=> retry_error_flag_q
        && state_q == txwb_pkg::ST_WB)
        else $error("single attempt retry error missing");
    retry_again_a: assert property (ev_fail && !disable_retry_q && fails_q < txwb_pkg::LAST_FAIL
        |=> retry_req_o && !retry_error_flag_q && fails_q == $past(fails_q) + 5'h01)
        else $error("retry not requested");
    carrier_keep_a: assert property (in_send && carrier_lost_i && !late_coll_i
        && !underflow_i && !attempt_fail_i && left_q != 12'h000
        |=> carrier_loss_flag_q && in_send)
        else $error("carrier loss aborted the frame or went unflagged");
    buffer_error_flag_stop_a: assert property (wait_bad |=> buffer_error_flag_q && underflow_flag_q && !transmitter_on_q
        ##1 wb_valid_o && wb_status_o[txwb_pkg::BUFFER_ERROR_FLAG_BIT])
        else $error("buffer error mishandled");
    err_sum_a: assert property (wb_valid_o |-> wb_flags_o[txwb_pkg::ERR_BIT]
        == (wb_status_o[txwb_pkg::UNDERFLOW_FLAG_BIT] || wb_status_o[txwb_pkg::LATE_COLLISION_FLAG_BIT]
        || wb_status_o[txwb_pkg::CARRIER_LOSS_FLAG_BIT] || wb_status_o[txwb_pkg::RETRY_ERROR_FLAG_BIT]))
        else $error("error summary wrong");
    retry_count_a: assert property (wb_valid_o && (wb_flags_o[txwb_pkg::ENP_BIT]
        || wb_flags_o[txwb_pkg::ERR_BIT]) |-> wb_flags_o[txwb_pkg::MORE_BIT]
        == (fails_q > 5'h01) && wb_flags_o[txwb_pkg::ONE_BIT] == (fails_q == 5'h01))
        else $error("retry count flags wrong");
    single_buf_a: assert property (ev_buf_end && flags_q[txwb_pkg::ENP_BIT]
        |=> state_q == txwb_pkg::ST_WB)
        else $error("single buffer frame chained");
endmodule

// ===== logic/txwb_log_mem.sv
`timescale 1ns/1ps
module txwb_log_mem
(
    input wire logic ref_clk_i,
    input wire logic wr_en_i,
    input wire logic [txwb_pkg::LOG_AW-1:0] wr_addr_i,
    input wire logic [15:0] wr_data_i,
    input wire logic rd_en_i,
    input wire logic [txwb_pkg::LOG_AW-1:0] rd_addr_i,
    output logic [15:0] rd_data_o
);
    logic [15:0] mem_q [txwb_pkg::LOG_DEPTH];

    always_ff @(posedge ref_clk_i)
    begin
        if (wr_en_i)
        begin
            mem_q[wr_addr_i] <= wr_data_i;
        end
    end

    // no reset: contents are only history, read data is registered
    always_ff @(posedge ref_clk_i)
    begin
        if (rd_en_i)
        begin
            rd_data_o <= mem_q[rd_addr_i];
        end
    end
endmodule

// ===== logic/txwb_pkg.sv
package txwb_pkg;
    // register map, byte offsets on the 8-bit register port
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_INT_STATUS = 8'h08;
    localparam logic [7:0] REG_INT_MASK = 8'h0C;
    localparam logic [7:0] REG_LOG_BASE = 8'h20;
    // control register fields
    localparam int CTRL_TRANSMITTER_ON_BIT = 0;
    localparam int CTRL_DISABLE_RETRY_BIT = 1;
    localparam int CTRL_DISABLE_TX_CRC_BIT = 2;
    // status register fields
    localparam int STAT_TRANSMITTER_ON_BIT = 0;
    localparam int STAT_FRAME_BIT = 1;
    localparam int STAT_FAILS_LSB = 2;
    // interrupt fields
    localparam int INT_W = 3;
    localparam int INT_DONE_BIT = 0;
    localparam int INT_ERR_BIT = 1;
    localparam int INT_BUFFER_ERROR_FLAG_BIT = 2;
    // descriptor flag word fields
    localparam int OWN_BIT = 15;
    localparam int ERR_BIT = 14;
    localparam int CRC_BIT = 13;
    localparam int MORE_BIT = 12;
    localparam int ONE_BIT = 11;
    localparam int STP_BIT = 9;
    localparam int ENP_BIT = 8;
    // descriptor count word fields
    localparam int LEN_MSB = 11;
    // status word fields
    localparam int BUFFER_ERROR_FLAG_BIT = 15;
    localparam int UNDERFLOW_FLAG_BIT = 14;
    localparam int LATE_COLLISION_FLAG_BIT = 12;
    localparam int CARRIER_LOSS_FLAG_BIT = 11;
    localparam int RETRY_ERROR_FLAG_BIT = 10;
    // attempt limit
    localparam logic [4:0] LAST_FAIL = 5'h0F;
    // status log
    localparam int LOG_AW = 3;
    localparam int LOG_DEPTH = 8;
    // reset values
    localparam logic [15:0] WORD_RST = 16'h0000;
    localparam logic [11:0] LEN_RST = 12'h000;
    localparam logic [4:0] FAILS_RST = 5'h00;
    localparam logic [2:0] INT_RST = 3'h0;
    localparam logic [2:0] LOG_PTR_RST = 3'h0;

    typedef enum logic [3:0]
    {
        ST_IDLE = 4'b0001,
        ST_SEND = 4'b0010,
        ST_WAIT_NEXT = 4'b0100,
        ST_WB = 4'b1000
    } txwb_state_e;
endpackage

// ===== testbench/testbench.sv
`timescale 1ns/1ps
module testbench;
    logic ref_clk_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic [7:0] reg_addr_i = 8'h00;
    logic [15:0] reg_wdata_i = 16'h0000;
    logic reg_we_i = 1'b0;
    logic reg_re_i = 1'b0;
    logic desc_load_i = 1'b0;
    logic [15:0] desc_flags_i = 16'h0000;
    logic [15:0] desc_count_i = 16'h0000;
    logic attempt_fail_i = 1'b0;
    logic late_coll_i = 1'b0;
    logic carrier_lost_i = 1'b0;
    logic underflow_i = 1'b0;
    logic next_status_i = 1'b0;
    logic next_own_i = 1'b0;
    logic slow = 1'b0;
    logic byte_take_i, desc_ready_o, crc_enable_o, sending_o, retry_req_o, wb_valid_o;
    logic transmitter_on_o, irq_o, not_sending;
    logic [11:0] bytes_left_o;
    logic [15:0] reg_rdata_o, wb_flags_o, wb_status_o, wb_count_o;
    logic [2:0] m;
    int n_mismatch = 0;
    int checked = 0;
    int n_bytes = 0;
    int n_retry = 0;

    always #5 ref_clk_i = ~ref_clk_i;
    always_comb not_sending = !sending_o;

    txwb_core dut (.ref_clk_i, .reset_n_i, .reg_addr_i, .reg_wdata_i, .reg_we_i, .reg_re_i,
        .reg_rdata_o, .desc_load_i, .desc_flags_i, .desc_count_i, .desc_ready_o, .byte_take_i,
        .bytes_left_o, .crc_enable_o, .sending_o, .attempt_fail_i, .late_coll_i,
        .carrier_lost_i, .underflow_i, .next_status_i, .next_own_i, .retry_req_o,
        .wb_valid_o, .wb_flags_o, .wb_status_o, .wb_count_o, .transmitter_on_o, .irq_o);
    txwb_engine_model eng (.ref_clk_i, .reset_n_i, .slow_i(slow), .sending_i(sending_o),
        .bytes_left_i(bytes_left_o), .byte_take_o(byte_take_i));

    always @(posedge ref_clk_i)
    begin
        if (desc_load_i)
            n_bytes <= 0;
        else if (byte_take_i && sending_o && bytes_left_o != 12'h000)
            n_bytes <= n_bytes + 1;
        if (retry_req_o)
            n_retry <= n_retry + 1;
    end

    task automatic end_of_test();
        $display("mismatches %0d checks %0d", n_mismatch, checked);
        if (n_mismatch == 0 && checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
        checked++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("BAD t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk_i);
    endtask

    task automatic wait_hi(ref logic s);
        int i;
        i = 0;
        while (s !== 1'b1 && i < 400)
        begin
            @(posedge ref_clk_i);
            i++;
        end
        if (i >= 400)
        begin
            n_mismatch++;
            $display("BAD t=%0t wait timed out", $time);
            end_of_test();
        end
    endtask

    task automatic reg_wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge ref_clk_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_we_i <= 1'b1;
        @(posedge ref_clk_i);
        reg_we_i <= 1'b0;
    endtask

    task automatic reg_rd(input logic [7:0] a, input logic [15:0] exp, input string what);
        @(posedge ref_clk_i);
        reg_addr_i <= a;
        reg_re_i <= 1'b1;
        @(posedge ref_clk_i);
        reg_re_i <= 1'b0;
        @(posedge ref_clk_i);
        check(reg_rdata_o, exp, what);
    endtask

    // 0 fail, 1 late collision, 2 carrier, 3 next unowned, 4 underflow
    task automatic pulse(input int w);
        @(posedge ref_clk_i);
        if (w < 3)
            wait_hi(sending_o);
        else
            wait_hi(not_sending);
        attempt_fail_i <= (w == 0);
        late_coll_i <= (w == 1);
        carrier_lost_i <= (w == 2);
        next_status_i <= (w == 3);
        underflow_i <= (w == 4);
        @(posedge ref_clk_i);
        {attempt_fail_i, late_coll_i, carrier_lost_i, next_status_i, underflow_i} <= 5'h00;
    endtask

    function automatic logic [15:0] exp_status(input int kind);
        case (kind)
            3, 6: exp_status = 16'h0400;
            4: exp_status = 16'h1000;
            5: exp_status = 16'h0800;
            7, 8: exp_status = 16'hC000;
            default: exp_status = 16'h0000;
        endcase
    endfunction

    function automatic int exp_retry(input int kind);
        exp_retry = (kind == 3) ? 15 : ((kind == 1 || kind == 2) ? kind : 0);
    endfunction

    function automatic logic [15:0] exp_flags(input int kind, input logic [15:0] fl);
        exp_flags = fl & 16'h27FF;
        if (exp_status(kind) != 16'h0000)
            exp_flags[14] = 1'b1;
        exp_flags[11] = (kind == 1);
        exp_flags[12] = (kind == 2 || kind == 3);
    endfunction

    // kinds: 0 clean, 1/2 one/two fails, 3 sixteen fails, 4 late, 5 carrier,
    // 6 fail with retries off, 7/8 chain stalls on unowned next or underflow
    task automatic frame(input int kind, input int len, input logic crc);
        logic [15:0] fl, cnt;
        fl = {2'b10, crc, 5'h02, 8'h5A};
        if (kind < 7)
            fl[8] = 1'b1;
        cnt = {4'hF, 12'(-len)};
        n_retry = 0;
        wait_hi(desc_ready_o);
        desc_flags_i <= fl;
        desc_count_i <= cnt;
        desc_load_i <= 1'b1;
        @(posedge ref_clk_i);
        desc_load_i <= 1'b0;
        if (kind == 0)
        begin
            @(posedge ref_clk_i);
            check({15'h0000, crc_enable_o}, {15'h0000, crc}, "crc enable");
        end
        else if (kind == 3)
            repeat (16) pulse(0);
        else if (kind > 6)
            pulse(kind - 4);
        else
            repeat (kind == 2 ? 2 : 1) pulse(kind == 4 ? 1 : (kind == 5 ? 2 : 0));
        wait_hi(wb_valid_o);
        check(wb_flags_o, exp_flags(kind, fl), "flags");
        check(wb_status_o, exp_status(kind), "status");
        check(wb_count_o, cnt, "count");
        check(16'(n_retry), 16'(exp_retry(kind)), "retries");
        if (kind == 0 || kind == 5 || kind == 7)
            check(16'(n_bytes), 16'(len), "bytes sent");
        if (kind > 6)
        begin
            cyc(1);
            check({15'h0000, transmitter_on_o}, 16'h0000, "tx on");
        end
    endtask

    initial
    begin
        void'($urandom(38));
        cyc(10);
        reset_n_i <= 1'b1;
        reg_rd(txwb_pkg::REG_STATUS, 16'h0000, "status at reset");
        reg_rd(8'h10, 16'h0000, "unmapped");
        reg_wr(txwb_pkg::REG_CTRL, 16'h0005);
        reg_rd(txwb_pkg::REG_STATUS, 16'h0001, "status on");
        frame(0, 0, 1'b1);
        for (int k = 1; k <= 8; k++)
        begin
            slow <= 1'b1;
            if (k == 6)
                reg_wr(txwb_pkg::REG_CTRL, 16'h0007);
            frame(k, (k > 6) ? 3 : 8, 1'b0);
            if (k > 5)
                reg_wr(txwb_pkg::REG_CTRL, 16'h0005);
        end
        reg_rd(txwb_pkg::REG_INT_STATUS, 16'h0007, "int after errors");
        reg_rd(txwb_pkg::REG_LOG_BASE + 8'h10, exp_status(4), "log entry");
        reg_wr(txwb_pkg::REG_INT_STATUS, 16'h0007);
        repeat (12)
        begin
            m = 3'($urandom_range(0, 7));
            reg_wr(txwb_pkg::REG_INT_MASK, {13'h0000, m});
            slow <= 1'($urandom_range(0, 1));
            frame(0, $urandom_range(0, 40), 1'($urandom_range(0, 1)));
            cyc(2);
            check({15'h0000, irq_o}, {15'h0000, m[0]}, "irq raised");
            reg_rd(txwb_pkg::REG_INT_STATUS, 16'h0001, "int status");
            reg_wr(txwb_pkg::REG_INT_STATUS, 16'h0001);
            @(posedge ref_clk_i);
            check({15'h0000, irq_o}, 16'h0000, "irq cleared");
        end
        end_of_test();
    end
endmodule

// ===== testbench/txwb_engine_model.sv
`timescale 1ns/1ps
module txwb_engine_model
(
    input wire logic ref_clk_i,
    input wire logic reset_n_i,
    input wire logic slow_i,
    input wire logic sending_i,
    input wire logic [11:0] bytes_left_i,
    output logic byte_take_o
);
    logic [1:0] pace_q;

    // one byte per two cycles, one per four when stalling; never ahead of the count
    always_ff @(posedge ref_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            pace_q <= 2'h0;
            byte_take_o <= 1'b0;
        end
        else
        begin
            pace_q <= pace_q + 2'h1;
            byte_take_o <= sending_i && (bytes_left_i != 12'h000)
                && (slow_i ? (pace_q == 2'h0) : !pace_q[0]);
        end
    end
endmodule
